/* drrb_top.v */
// Data register ROM backup engine with AXI4-Lite register access.
// Assumes scan_end is a one-cycle pulse and storage answers with rom_ack.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "drrb_consts.vh"
module drrb_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire scan_end,
    input wire rom_present,
    input wire rom_image_valid,
    output reg rom_req,
    output reg rom_we,
    output reg [10:0] rom_addr,
    output reg [15:0] rom_wdata,
    input wire rom_ack,
    input wire rom_err,
    input wire [15:0] rom_rdata,
    output reg xfer_busy,
    output wire irq
);
    // Engine states, one-hot
    localparam S_IDLE = 8'b00000001;
    localparam S_SRD = 8'b00000010;
    localparam S_SWT = 8'b00000100;
    localparam S_SREQ = 8'b00001000;
    localparam S_LCHK = 8'b00010000;
    localparam S_LREQ = 8'b00100000;
    localparam S_LWR = 8'b01000000;
    localparam S_FIN = 8'b10000000;

    reg [7:0] state_q; // Engine state
    reg [10:0] idx_q; // Current word index
    reg [10:0] end_q; // Last index of a load
    reg [15:0] ld_data_q; // Word fetched from storage
    reg [2:0] code_q; // Outcome waiting to be posted
    reg took_save_q; // Save was part of this run
    reg took_load_q; // Load was part of this run
    reg clr_save_q; // Hardware clear of save request
    reg clr_load_q; // Hardware clear of load request
    reg [2:0] ev_q; // Event pulses to interrupt logic
    reg rom_save_request_q; // Save request flag
    reg rom_load_request_q; // Load request flag
    reg [2:0] rom_transfer_status_q; // Outcome code
    reg [11:0] load_start_index_q; // First register to load
    reg [11:0] load_word_count_q; // Number of registers to load
    reg [10:0] ptr_q; // Software window pointer

    // Bus side state
    reg aw_held_q; // Write address captured
    reg w_held_q; // Write data captured
    reg [7:0] aw_addr_q; // Captured write address
    reg [31:0] w_data_q; // Captured write data
    reg [3:0] w_strb_q; // Captured byte strobes
    reg [7:0] ar_addr_q; // Captured read address
    reg rd_p1_q; // Read stage one
    reg rd_p2_q; // Read stage two, array data ready

    wire busy = !state_q[0]; // Engine owns the array
    wire [15:0] mem_rdata; // Array read data
    wire [2:0] irq_stat; // Sticky status
    wire [2:0] irq_mask; // Mask
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid; // Write performed
    wire [12:0] range_sum = {1'b0, load_start_index_q} + {1'b0, load_word_count_q};
    wire ptr_ok = (ptr_q <= `DRRB_LAST); // Window pointer in range
    wire wr_unmapped = (aw_addr_q[7:5] != 3'h0); // Outside the map
    wire rd_unmapped = (ar_addr_q[7:5] != 3'h0);
    wire wr_data_win = (aw_addr_q == `DRRB_OFS_DDATA);
    wire wr_err = wr_unmapped || (wr_data_win && (busy || !ptr_ok));
    wire rd_err = rd_unmapped || ((ar_addr_q == `DRRB_OFS_DDATA) && (busy || !ptr_ok));
    wire sw_save_set = wr_fire && !wr_err && (aw_addr_q == `DRRB_OFS_CTRL)
        && w_strb_q[0] && w_data_q[`DRRB_CTRL_SAVE_BIT];
    wire sw_load_set = wr_fire && !wr_err && (aw_addr_q == `DRRB_OFS_CTRL)
        && w_strb_q[0] && w_data_q[`DRRB_CTRL_LOAD_BIT];
    wire mask_wr = wr_fire && (aw_addr_q == `DRRB_OFS_IRQ_MASK) && w_strb_q[0];
    wire stat_rd_clr = rd_p2_q && (ar_addr_q == `DRRB_OFS_IRQ_STAT);
    wire [15:0] start_mrg = merge({4'h0, load_start_index_q}, w_data_q[15:0], w_strb_q[1:0]); // New start
    wire [15:0] count_mrg = merge({4'h0, load_word_count_q}, w_data_q[15:0], w_strb_q[1:0]); // New count
    wire [15:0] ptr_mrg = merge({5'h00, ptr_q}, w_data_q[15:0], w_strb_q[1:0]); // New pointer

    // Array port: engine while busy, software window otherwise
    wire [10:0] mem_addr = busy ? idx_q : ptr_q;
    wire mem_we = state_q[6] || (wr_fire && !wr_err && wr_data_win);
    wire [15:0] mem_wdata = busy ? ld_data_q : merge(16'h0000, w_data_q[15:0], w_strb_q[1:0]);

    // Byte-lane merge of a write into an old value
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] strb;
        begin
            merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    drrb_mem #(
        .AW(11),
        .DW(16),
        .DEPTH(2000)
    ) u_mem (
        .aclk(aclk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata_q(mem_rdata)
    );

    drrb_irq #(
        .N(3)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .ev_set(ev_q),
        .stat_rd_clr(stat_rd_clr),
        .mask_wr(mask_wr),
        .mask_wdata(w_data_q[2:0]),
        .stat_q(irq_stat),
        .mask_q(irq_mask),
        .irq_q(irq)
    );

    // Request flags: software sets, engine clears, set wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            rom_save_request_q <= 1'b0;
            rom_load_request_q <= 1'b0;
        end else begin
            if (sw_save_set)
                rom_save_request_q <= 1'b1;
            else if (clr_save_q)
                rom_save_request_q <= 1'b0;
            if (sw_load_set)
                rom_load_request_q <= 1'b1;
            else if (clr_load_q)
                rom_load_request_q <= 1'b0;
        end
    end

    // Software configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            load_start_index_q <= `DRRB_START_RST;
            load_word_count_q <= `DRRB_COUNT_RST;
            ptr_q <= `DRRB_PTR_RST;
        end else if (wr_fire && !wr_err) begin
            case (aw_addr_q)
                `DRRB_OFS_START: load_start_index_q <= start_mrg[11:0];
                `DRRB_OFS_COUNT: load_word_count_q <= count_mrg[11:0];
                `DRRB_OFS_DPTR: ptr_q <= ptr_mrg[10:0];
                default: ptr_q <= ptr_q; // Other offsets store nothing here
            endcase
        end
    end

    // Transfer engine
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            idx_q <= 11'h000;
            end_q <= 11'h000;
            ld_data_q <= 16'h0000;
            code_q <= `DRRB_ST_NONE;
            took_save_q <= 1'b0;
            took_load_q <= 1'b0;
            clr_save_q <= 1'b0;
            clr_load_q <= 1'b0;
            ev_q <= 3'h0;
            rom_transfer_status_q <= `DRRB_ST_NONE;
            rom_req <= 1'b0;
            rom_we <= 1'b0;
            rom_addr <= 11'h000;
            rom_wdata <= 16'h0000;
            xfer_busy <= 1'b0;
        end else begin
            clr_save_q <= 1'b0;
            clr_load_q <= 1'b0;
            ev_q <= 3'h0;
            case (state_q)
                S_IDLE: begin
                    // Requests are looked at only at scan end
                    if (scan_end && (rom_save_request_q || rom_load_request_q)) begin
                        took_save_q <= rom_save_request_q;
                        took_load_q <= rom_load_request_q;
                        rom_transfer_status_q <= `DRRB_ST_BUSY;
                        xfer_busy <= 1'b1;
                        idx_q <= 11'h000;
                        if (rom_save_request_q) begin
                            if (!rom_present) begin
                                code_q <= `DRRB_ST_NOROM;
                                state_q <= S_FIN;
                            end else begin
                                state_q <= S_SRD;
                            end
                        end else begin
                            state_q <= S_LCHK;
                        end
                    end
                end
                S_SRD: state_q <= S_SWT; // Array address applied this cycle
                S_SWT: begin
                    // Array word ready, hand it to storage
                    rom_req <= 1'b1;
                    rom_we <= 1'b1;
                    rom_addr <= idx_q;
                    rom_wdata <= mem_rdata;
                    state_q <= S_SREQ;
                end
                S_SREQ: begin
                    if (rom_ack) begin
                        rom_req <= 1'b0;
                        rom_we <= 1'b0;
                        if (rom_err) begin
                            code_q <= `DRRB_ST_NOROM;
                            state_q <= S_FIN;
                        end else if (idx_q == `DRRB_LAST) begin
                            // Whole array written
                            if (took_load_q) begin
                                state_q <= S_LCHK;
                            end else begin
                                code_q <= `DRRB_ST_OK;
                                state_q <= S_FIN;
                            end
                        end else begin
                            idx_q <= idx_q + 11'h001;
                            state_q <= S_SRD;
                        end
                    end
                end
                S_LCHK: begin
                    // Range and storage checks before any word moves
                    if (!rom_present) begin
                        code_q <= `DRRB_ST_NOROM;
                        state_q <= S_FIN;
                    end else if ((load_word_count_q == 12'h000)
                        || (load_start_index_q > {1'b0, `DRRB_LAST})
                        || (range_sum > `DRRB_NWORDS)) begin
                        code_q <= `DRRB_ST_BADRANGE;
                        state_q <= S_FIN;
                    end else if (!rom_image_valid) begin
                        code_q <= `DRRB_ST_NODATA;
                        state_q <= S_FIN;
                    end else begin
                        idx_q <= load_start_index_q[10:0];
                        end_q <= range_sum[10:0] - 11'h001;
                        rom_req <= 1'b1;
                        rom_we <= 1'b0;
                        rom_addr <= load_start_index_q[10:0];
                        state_q <= S_LREQ;
                    end
                end
                S_LREQ: begin
                    if (rom_ack) begin
                        rom_req <= 1'b0;
                        if (rom_err) begin
                            code_q <= `DRRB_ST_NOROM;
                            state_q <= S_FIN;
                        end else begin
                            ld_data_q <= rom_rdata;
                            state_q <= S_LWR;
                        end
                    end
                end
                S_LWR: begin
                    // Word written into the array this cycle
                    if (idx_q == end_q) begin
                        code_q <= `DRRB_ST_OK;
                        state_q <= S_FIN;
                    end else begin
                        idx_q <= idx_q + 11'h001;
                        rom_req <= 1'b1;
                        rom_addr <= idx_q + 11'h001;
                        state_q <= S_LREQ;
                    end
                end
                S_FIN: begin
                    // Post outcome; request flags drop on the edge after the outcome posts
                    rom_transfer_status_q <= code_q;
                    clr_save_q <= took_save_q;
                    clr_load_q <= took_load_q;
                    ev_q[`DRRB_EV_SAVE_BIT] <= took_save_q && (code_q == `DRRB_ST_OK);
                    ev_q[`DRRB_EV_LOAD_BIT] <= took_load_q && (code_q == `DRRB_ST_OK);
                    ev_q[`DRRB_EV_ERR_BIT] <= (code_q != `DRRB_ST_OK);
                    xfer_busy <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // AXI write channels: address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DRRB_RESP_OKAY;
        end else begin
            // Ready only while the holding slot is empty
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `DRRB_RESP_SLVERR : `DRRB_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // AXI read channel: two stages so array data settle
    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_addr_q <= 8'h00;
            rd_p1_q <= 1'b0;
            rd_p2_q <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DRRB_RESP_OKAY;
        end else begin
            s_axi_arready <= !rd_p1_q && !rd_p2_q && !s_axi_rvalid
                && !(s_axi_arvalid && s_axi_arready);
            rd_p1_q <= s_axi_arvalid && s_axi_arready;
            rd_p2_q <= rd_p1_q;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr_q <= {s_axi_araddr[7:2], 2'b00};
            end
            if (rd_p2_q) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_err ? `DRRB_RESP_SLVERR : `DRRB_RESP_OKAY;
                case (rd_err ? 8'hff : ar_addr_q)
                    `DRRB_OFS_CTRL: s_axi_rdata <= {30'h0, rom_load_request_q, rom_save_request_q};
                    `DRRB_OFS_STATUS: s_axi_rdata <= {29'h0, rom_transfer_status_q};
                    `DRRB_OFS_START: s_axi_rdata <= {20'h0, load_start_index_q};
                    `DRRB_OFS_COUNT: s_axi_rdata <= {20'h0, load_word_count_q};
                    `DRRB_OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
                    `DRRB_OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                    `DRRB_OFS_DPTR: s_axi_rdata <= {21'h0, ptr_q};
                    `DRRB_OFS_DDATA: s_axi_rdata <= {16'h0, mem_rdata};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // drrb_top

/* drrb_consts.vh */
// Constants for the data register ROM backup block: register offsets,
// field positions, reset values, status codes and array sizes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DRRB_CONSTS_VH
`define DRRB_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define DRRB_OFS_CTRL 8'h00
`define DRRB_OFS_STATUS 8'h04
`define DRRB_OFS_START 8'h08
`define DRRB_OFS_COUNT 8'h0c
`define DRRB_OFS_IRQ_STAT 8'h10
`define DRRB_OFS_IRQ_MASK 8'h14
`define DRRB_OFS_DPTR 8'h18
`define DRRB_OFS_DDATA 8'h1c

// Control register field positions
`define DRRB_CTRL_SAVE_BIT 0
`define DRRB_CTRL_LOAD_BIT 1

// Interrupt event bit positions
`define DRRB_EV_SAVE_BIT 0
`define DRRB_EV_LOAD_BIT 1
`define DRRB_EV_ERR_BIT 2

// Transfer status codes
`define DRRB_ST_NONE 3'h0
`define DRRB_ST_BUSY 3'h1
`define DRRB_ST_OK 3'h2
`define DRRB_ST_NOROM 3'h3
`define DRRB_ST_BADRANGE 3'h4
`define DRRB_ST_NODATA 3'h5

// Data register array size
`define DRRB_NWORDS 13'h07d0
`define DRRB_LAST 11'h7cf

// Reset values
`define DRRB_START_RST 12'h000
`define DRRB_COUNT_RST 12'h000
`define DRRB_MASK_RST 3'h0
`define DRRB_PTR_RST 11'h000

// AXI responses
`define DRRB_RESP_OKAY 2'h0
`define DRRB_RESP_SLVERR 2'h2

`endif

/* drrb_mem.v */
// Data register array: single port, registered read data.
// Assumes one access per clock; a write and a read never need the same cycle.
`timescale 1ns/100ps
module drrb_mem #(
    parameter AW = 11,
    parameter DW = 16,
    parameter DEPTH = 2000
) (
    input wire aclk,
    input wire [AW-1:0] addr,
    input wire we,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata_q
);
    // Storage words
    reg [DW-1:0] mem [0:DEPTH-1];

    // Write port and registered read port
    always @(posedge aclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule // drrb_mem

/* drrb_irq.v */
// Sticky interrupt status with mask and one level interrupt output.
// Assumes event pulses and the read-clear strobe come from the same clock.
`timescale 1ns/100ps
`include "drrb_consts.vh"
module drrb_irq #(
    parameter N = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [N-1:0] ev_set,
    input wire stat_rd_clr,
    input wire mask_wr,
    input wire [N-1:0] mask_wdata,
    output reg [N-1:0] stat_q,
    output reg [N-1:0] mask_q,
    output reg irq_q
);
    // Next values
    reg [N-1:0] stat_d;
    reg [N-1:0] mask_d;

    // Read clears, a new event in the same cycle wins
    always @* begin
        stat_d = (stat_rd_clr ? {N{1'b0}} : stat_q) | ev_set;
        mask_d = mask_wr ? mask_wdata : mask_q;
    end

    // Status, mask and the level output
    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= {N{1'b0}};
            mask_q <= `DRRB_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
        end
    end
endmodule // drrb_irq

/* drrb_props.sv */
// Checker: storage link order and bus answer times.
// Assumes binding to drrb_top; sees only its ports.
`timescale 1ns/100ps
module drrb_props (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic scan_end,
    input logic rom_req,
    input logic rom_we,
    input logic [10:0] rom_addr,
    input logic rom_ack,
    input logic xfer_busy
);
    logic [11:0] wr_cnt_q; // Save words acked this run
    logic [11:0] rd_nxt_q; // Next load index expected
    logic rd_on_q; // A load word was acked this run
    // Link progress in one run
    always @(posedge aclk) begin
        if (!xfer_busy) begin
            wr_cnt_q <= 12'h000;
            rd_on_q <= 1'b0;
        end else if (rom_req && rom_ack && rom_we) begin
            wr_cnt_q <= wr_cnt_q + 12'h001;
        end else if (rom_req && rom_ack) begin
            rd_nxt_q <= {1'b0, rom_addr} + 12'h001;
            rd_on_q <= 1'b1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    property p_b_time; s_wr_take |-> ##2 s_axi_bvalid; endproperty
    a_b_time: assert property (p_b_time) else $error("write answer late");
    property p_r_time; s_rd_take |-> ##3 s_axi_rvalid; endproperty
    a_r_time: assert property (p_r_time) else $error("read answer late");
    property p_req_hold; rom_req && !rom_ack |=> rom_req && $stable(rom_addr) && $stable(rom_we); endproperty
    a_req_hold: assert property (p_req_hold) else $error("link request moved");
    property p_req_drop; rom_req && rom_ack |=> !rom_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("link request kept");
    property p_idle; !xfer_busy |-> !rom_req; endproperty
    a_idle: assert property (p_idle) else $error("link used while idle");
    property p_start; $rose(xfer_busy) |-> $past(scan_end); endproperty
    a_start: assert property (p_start) else $error("run began without scan end");
    property p_save_seq; rom_req && rom_we |-> rom_addr == wr_cnt_q[10:0]; endproperty
    a_save_seq: assert property (p_save_seq) else $error("save index out of order");
    property p_save_all; $fell(xfer_busy) |-> wr_cnt_q == 12'h000 || wr_cnt_q == 12'h7d0; endproperty
    a_save_all: assert property (p_save_all) else $error("save word count wrong");
    property p_load_seq; $rose(rom_req) && !rom_we && rd_on_q |-> rom_addr == rd_nxt_q[10:0]; endproperty
    a_load_seq: assert property (p_load_seq) else $error("load index out of order");
    property p_range; rom_req |-> rom_addr <= 11'h7cf; endproperty
    a_range: assert property (p_range) else $error("link index past array");
endmodule // drrb_props
bind drrb_top drrb_props i_drrb_props (.*);

/* drrb_rom_model.sv */
// Storage model: 2000-word image answering each link request.
// Assumes the block holds its request until it sees the answer.
`timescale 1ns/100ps
module drrb_rom_model (
    input logic aclk,
    input logic slow,
    input logic rom_req,
    input logic rom_we,
    input logic [10:0] rom_addr,
    input logic [15:0] rom_wdata,
    output logic rom_ack,
    output logic [15:0] rom_rdata
);
    logic [15:0] mem [0:1999]; // Stored image
    logic [2:0] wait_q; // Cycles spent on this request
    // Known image before any save
    initial begin
        for (int i = 0; i < 2000; i++) mem[i] = 16'(i) ^ 16'h1234;
        rom_ack = 1'b0;
        wait_q = 3'h0;
        rom_rdata = 16'h0000;
    end
    // Answer after one or seven cycles
    always @(posedge aclk) begin
        rom_ack <= 1'b0;
        rom_rdata <= ~rom_rdata; // Data not held outside an answer
        if (rom_req && !rom_ack) begin
            wait_q <= wait_q + 3'h1;
            if (wait_q >= (slow ? 3'h6 : 3'h0)) begin
                rom_ack <= 1'b1;
                wait_q <= 3'h0;
                if (rom_we) mem[rom_addr] <= rom_wdata;
                else rom_rdata <= mem[rom_addr];
            end
        end
    end
endmodule // drrb_rom_model

/* drrb_top_tb.sv */
// Backup block bench: bus tasks, scan runs, expected results.
// Assumes design, storage model and checker compiled with it.
`timescale 1ns/100ps
`include "drrb_consts.vh"
module drrb_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scan_end, rom_present, rom_image_valid;
    logic rom_req, rom_we, rom_ack, rom_err, xfer_busy, irq, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [10:0] rom_addr;
    logic [15:0] rom_wdata, rom_rdata;
    int error_cnt, checks_done;
    int edge_idx[4] = '{99, 100, 179, 180}; // Words around the load range
    // Start, count, present, image valid, request, status
    int bad_tab[6][6] = '{'{0, 0, 1, 1, 2, 4}, '{32'h7d0, 1, 1, 1, 2, 4}, '{32'h7cf, 2, 1, 1, 2, 4},
        '{0, 1, 0, 1, 2, 3}, '{0, 1, 1, 0, 2, 5}, '{0, 1, 0, 1, 1, 3}};
    drrb_top i_drrb_top (.*);
    drrb_rom_model i_drrb_rom_model (.*);
    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Compare and count
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    // Verdict and end of run
    task stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Bounded clock wait
    task tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 40000) begin
            $display("mismatch timeout exp %0d got %0d", 40000, n);
            error_cnt++;
            stop_test();
        end
    endtask
    // Bus write; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    // Bus read; rready stays high
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", e, s_axi_rdata);
    endtask
    // Array word through the window
    task wa(input int i, input logic [15:0] v);
        wr(`DRRB_OFS_DPTR, 32'(i));
        wr(`DRRB_OFS_DDATA, {16'h0, v});
    endtask
    task ra(input int i, input logic [15:0] e);
        wr(`DRRB_OFS_DPTR, 32'(i));
        rd(`DRRB_OFS_DDATA, {16'h0, e});
    endtask
    // Flags, scan end, outcome
    task automatic run(input logic [31:0] req, input logic [2:0] st);
        int n = 0;
        wr(`DRRB_OFS_CTRL, req);
        scan_end <= 1'b1;
        @(posedge aclk);
        scan_end <= 1'b0;
        if (req[0] && st == `DRRB_ST_OK) rd(`DRRB_OFS_STATUS, {29'h0, `DRRB_ST_BUSY});
        do tick(n); while (xfer_busy);
        rd(`DRRB_OFS_STATUS, {29'h0, st});
        rd(`DRRB_OFS_CTRL, 32'h0);
    endtask
    // Main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, scan_end, slow, rom_err} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {rom_present, rom_image_valid, s_axi_bready, s_axi_rready} = 4'hf;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`DRRB_OFS_STATUS, 32'h0);
        rd(8'h20, 32'h0, `DRRB_RESP_SLVERR);
        wr(`DRRB_OFS_IRQ_MASK, 32'h4);
        wr(`DRRB_OFS_START, 32'h0);
        wr(`DRRB_OFS_COUNT, 32'h7d0);
        run(32'h2, `DRRB_ST_OK);
        ra(0, 16'h1234);
        ra(1999, 16'h07cf ^ 16'h1234);
        wa(0, 16'h0bad);
        wa(1999, 16'hbeef);
        run(32'h1, `DRRB_ST_OK);
        chk("rom_first", 32'h0bad, {16'h0, i_drrb_rom_model.mem[0]});
        chk("rom_last", 32'hbeef, {16'h0, i_drrb_rom_model.mem[1999]});
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(`DRRB_OFS_IRQ_STAT, 32'h3);
        foreach (edge_idx[k]) wa(edge_idx[k], 16'h0bad);
        slow <= 1'b1;
        wr(`DRRB_OFS_START, 32'h64);
        wr(`DRRB_OFS_COUNT, 32'h50);
        run(32'h2, `DRRB_ST_OK);
        foreach (edge_idx[k]) ra(edge_idx[k], (k == 1 || k == 2) ? 16'(edge_idx[k]) ^ 16'h1234 : 16'h0bad);
        slow <= 1'b0;
        foreach (bad_tab[k]) begin
            rom_present <= bad_tab[k][2][0];
            rom_image_valid <= bad_tab[k][3][0];
            wr(`DRRB_OFS_START, 32'(bad_tab[k][0]));
            wr(`DRRB_OFS_COUNT, 32'(bad_tab[k][1]));
            run(32'(bad_tab[k][4]), 3'(bad_tab[k][5]));
        end
        chk("irq_error", 32'h1, {31'h0, irq});
        rd(`DRRB_OFS_IRQ_STAT, 32'h6);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        {rom_present, rom_image_valid} <= 2'b11;
        wa(5, 16'h7777);
        wr(`DRRB_OFS_START, 32'h5);
        wr(`DRRB_OFS_COUNT, 32'h1);
        run(32'h3, `DRRB_ST_OK);
        ra(5, 16'h7777);
        chk("rom_both", 32'h7777, {16'h0, i_drrb_rom_model.mem[5]});
        stop_test();
    end
endmodule // drrb_top_tb
